// File: switch_bridge_status_regs.sv
// Purpose: Fault status and general status registers for switches and bridges
// Assumes: Fault detectors deliver synchronous level inputs; PWM and bridge
//          comparator pins are asynchronous and are synchronised here
// Notes: Read data appears one cycle after the read request
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Overtemperature flags of switches three, two, one sit at bits 12, 11, 10.
// - Open-load flags of switches three, two, one sit at bits 7, 6, 5.
// - Overcurrent flags of switches three, two, one sit at bits 2, 1, 0.
// - All reserved bits of both registers read as zero.
// - Power-on reset clears fault register; restart keeps the flag bits.
// - Bridge levels at bits 8:6 when mode is 11 and pump enabled.
// - Bridge level bit is zero when pump off or mode not 11.
// - Levels of PWM inputs two to six reported at bits 1 to 5.
// - Level of shared first PWM input reported at bit 0.
// - Restart clears general register except bits 7:6 and 0; reset clears all.
module switch_bridge_status_regs
  import status_regs_pkg::*;
#(
  parameter int SYNC_STAGES_UNUSED = 0
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic restart_in,
  input wire read_req_type read_req_in,
  input wire fault_events_type fault_events_in,
  input wire logic [NUM_BRIDGE*2-1:0] bridge_mode_field_in,
  input wire logic charge_pump_enable_in,
  input wire logic [NUM_BRIDGE-1:0] bridge_output_node_high_in,
  input wire logic [NUM_PWM-1:0] pwm_pin_in,
  output logic [REG_WIDTH-1:0] read_data_out,
  output logic read_valid_out
);
  // ==========================================================================
  // Pin synchronisation
  logic [NUM_PWM-1:0] pwm_sync;
  logic [NUM_BRIDGE-1:0] node_sync;

  sync_bits #(.WIDTH(NUM_PWM)) pwm_sync_inst (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .async_in(pwm_pin_in),
    .sync_out(pwm_sync)
  );

  sync_bits #(.WIDTH(NUM_BRIDGE)) node_sync_inst (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .async_in(bridge_output_node_high_in),
    .sync_out(node_sync)
  );

  // ==========================================================================
  // Address decode
  wire fault_hit = read_req_in.valid && (read_req_in.addr == FAULT_STATUS_ADDR);
  wire general_hit = read_req_in.valid && (read_req_in.addr == GENERAL_STATUS_ADDR);

  // ==========================================================================
  // Fault flags
  logic [3*NUM_SWITCH-1:0] fault_flags;

  sticky_flags #(.WIDTH(3*NUM_SWITCH)) fault_flags_inst (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .restart_in(restart_in),
    .event_in(fault_events_in),
    .clear_in(fault_hit),
    .flags_out(fault_flags)
  );

  fault_events_type flags_view;
  assign flags_view = fault_events_type'(fault_flags);

  logic [REG_WIDTH-1:0] fault_word;
  always_comb begin
    fault_word = '0;
    fault_word[OVERTEMP_LSB +: NUM_SWITCH] = flags_view.overtemp;
    fault_word[OPENLOAD_LSB +: NUM_SWITCH] = flags_view.openload;
    fault_word[OVERCURRENT_LSB +: NUM_SWITCH] = flags_view.overcurrent;
  end

  // ==========================================================================
  // General status, sampled each cycle
  logic [NUM_BRIDGE-1:0] bridge_level_d;
  logic [REG_WIDTH-1:0] general_d;
  logic [REG_WIDTH-1:0] general_q;

  genvar g;
  generate
    for (g = 0; g < NUM_BRIDGE; g++) begin : gen_bridge
      // Level only meaningful in sense mode with pump running
      assign bridge_level_d[g] = charge_pump_enable_in
        && (bridge_mode_field_in[2*g +: 2] == BRIDGE_MODE_SENSE)
        && node_sync[g];
    end
  endgenerate

  always_comb begin
    general_d = '0;
    general_d[BRIDGE_LEVEL_LSB +: NUM_BRIDGE] = bridge_level_d;
    general_d[PWM_LEVEL_LSB +: NUM_PWM] = pwm_sync;
  end

  // Restart clears all but bits 7:6 and 0, which are simply retained
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      general_q <= GENERAL_RESET_VALUE;
    end else if (restart_in) begin
      general_q <= general_q & GENERAL_RESTART_KEEP;
    end else begin
      general_q <= general_d;
    end
  end

  // ==========================================================================
  // Read port
  wire [REG_WIDTH-1:0] read_mux = fault_hit ? fault_word :
                                  general_hit ? general_q : '0;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      read_data_out <= '0;
      read_valid_out <= 1'b0;
    end else begin
      read_data_out <= read_mux;
      read_valid_out <= read_req_in.valid;
    end
  end
endmodule
`default_nettype wire

// File: status_regs_pkg.sv
// Purpose: Shared constants and types for the switch and bridge status registers
// Assumes: 16-bit registers, 7-bit register addresses on the host port
// Notes: Offsets are the register addresses as seen by the host
package status_regs_pkg;
  localparam int REG_WIDTH = 16;
  localparam int ADDR_WIDTH = 7;
  localparam int NUM_SWITCH = 3;
  localparam int NUM_BRIDGE = 3;
  localparam int NUM_PWM = 6;
  // ==========================================================================
  // Register offsets
  localparam logic [ADDR_WIDTH-1:0] FAULT_STATUS_ADDR = 7'h46;
  localparam logic [ADDR_WIDTH-1:0] GENERAL_STATUS_ADDR = 7'h50;
  // ==========================================================================
  // Field positions
  localparam int OVERTEMP_LSB = 10;
  localparam int OPENLOAD_LSB = 5;
  localparam int OVERCURRENT_LSB = 0;
  localparam int BRIDGE_LEVEL_LSB = 6;
  localparam int PWM_LEVEL_LSB = 0;
  // ==========================================================================
  // Reset values and masks
  localparam logic [REG_WIDTH-1:0] FAULT_RESET_VALUE = 16'h0000;
  localparam logic [REG_WIDTH-1:0] GENERAL_RESET_VALUE = 16'h0000;
  localparam logic [REG_WIDTH-1:0] FAULT_RESTART_KEEP = 16'h3FFF;
  localparam logic [REG_WIDTH-1:0] GENERAL_RESTART_KEEP = 16'h00C1;
  localparam logic [1:0] BRIDGE_MODE_SENSE = 2'h3;

  typedef struct packed {
    logic [NUM_SWITCH-1:0] overtemp;
    logic [NUM_SWITCH-1:0] openload;
    logic [NUM_SWITCH-1:0] overcurrent;
  } fault_events_type;

  typedef struct packed {
    logic valid;
    logic [ADDR_WIDTH-1:0] addr;
  } read_req_type;
endpackage

// File: sync_bits.sv
// Purpose: Two-stage synchroniser for a group of pin levels
// Assumes: Inputs asynchronous to mclk_in
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module sync_bits #(
  parameter int WIDTH = 1
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// File: sticky_flags.sv
// Purpose: Sticky fault flags cleared by a host read
// Assumes: Fault inputs are synchronous to mclk_in
// Notes: A live fault holds its flag through the clearing read
`timescale 1ns/1ps
`default_nettype none
module sticky_flags #(
  parameter int WIDTH = 9
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic restart_in,
  input wire logic [WIDTH-1:0] event_in,
  input wire logic clear_in,
  output logic [WIDTH-1:0] flags_out
);
  logic [WIDTH-1:0] flags_d;

  // Set beats clear so an event in the reading cycle is not lost
  assign flags_d = (clear_in ? '0 : flags_out) | event_in;

  // Restart keeps the flags, even through a read; only power-on or soft reset, or a host read outside restart, clears them
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      flags_out <= '0;
    end else if (!restart_in) begin
      flags_out <= flags_d;
    end
  end
endmodule
`default_nettype wire

// File: switch_bridge_status_regs_asserts.sv
// Purpose: port checker for the status registers. Assumes: answer one cycle on. Notes: no x tests
`timescale 1ns/1ps
`default_nettype none
module status_regs_asserts
  import status_regs_pkg::*;
(
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic restart_in,
  input wire read_req_type read_req_in,
  input wire fault_events_type fault_events_in,
  input wire logic [5:0] bridge_mode_field_in,
  input wire logic charge_pump_enable_in,
  input wire logic [2:0] bridge_output_node_high_in,
  input wire logic [5:0] pwm_pin_in,
  input wire logic [15:0] read_data_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  wire rd_f = read_req_in.valid && read_req_in.addr == FAULT_STATUS_ADDR;
  wire rd_g = read_req_in.valid && read_req_in.addr == GENERAL_STATUS_ADDR;
  // Restart freezes flags and masks levels, so every sequence excludes it
  wire hb_on = charge_pump_enable_in && bridge_mode_field_in[1:0] == 2'h3 && !restart_in;
  sequence s_hit(ev); !restart_in && ev ##1 rd_f; endsequence
  // The host needs two edges per read, so the second read lands two edges on
  sequence s_reread; rd_f && fault_events_in == '0 && !restart_in
    ##1 fault_events_in == '0 && !restart_in ##1 rd_f; endsequence
  property p_ot; s_hit(fault_events_in.overtemp[2]) |=> read_data_out[12]; endproperty
  a_ot: assert property (p_ot) else $error("overtemp flag missing");
  property p_ol; s_hit(fault_events_in.openload[1]) |=> read_data_out[6]; endproperty
  a_ol: assert property (p_ol) else $error("open-load flag missing");
  property p_oc; s_hit(fault_events_in.overcurrent[0]) |=> read_data_out[0]; endproperty
  a_oc: assert property (p_oc) else $error("overcurrent flag missing");
  property p_clr; s_reread |=> read_data_out == 16'h0000; endproperty
  a_clr: assert property (p_clr) else $error("flags not cleared by read");
  property p_hb; (hb_on && $stable(bridge_output_node_high_in))[*4] ##0 rd_g
    |=> read_data_out[6] == $past(bridge_output_node_high_in[0]); endproperty
  a_hb: assert property (p_hb) else $error("bridge level wrong");
  property p_hb0; (!charge_pump_enable_in && !restart_in)[*3] ##0 rd_g
    |=> read_data_out[8:6] == 3'h0; endproperty
  a_hb0: assert property (p_hb0) else $error("bridge level not forced low");
  property p_pwm; ($stable(pwm_pin_in) && !restart_in)[*4] ##0 rd_g
    |=> read_data_out[5:0] == $past(pwm_pin_in); endproperty
  a_pwm: assert property (p_pwm) else $error("pwm level wrong");
  property p_rst; $past(reset_in) && read_req_in.valid |=> read_data_out == 16'h0000; endproperty
  a_rst: assert property (p_rst) else $error("nonzero value after reset");
endmodule
bind switch_bridge_status_regs status_regs_asserts u_asserts (.mclk_in, .reset_in, .restart_in,
  .read_req_in, .fault_events_in, .bridge_mode_field_in, .charge_pump_enable_in,
  .bridge_output_node_high_in, .pwm_pin_in, .read_data_out);
`default_nettype wire

// File: status_host_model.sv
// Purpose: host read model
// Assumes: called just after a rising edge
// Notes: data taken at the edge that samples the answer; x if unanswered
`timescale 1ns/1ps
`default_nettype none
module status_host_model
  import status_regs_pkg::*;
(
  input wire logic mclk_in,
  output var read_req_type req_out,
  input wire logic [15:0] data_in,
  input wire logic valid_in
);
  initial req_out = '0;
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    req_out <= {1'b1, a};
    @(posedge mclk_in);
    req_out <= '0;
    @(posedge mclk_in);
    d = (valid_in === 1'b1) ? data_in : 'x;
  endtask
endmodule
`default_nettype wire

// File: switch_bridge_status_regs_tb.sv
// Purpose: status register bench. Assumes: inputs change at rising edges. Notes: pins held 4 cycles
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e, m) begin u_host.rd(a, d); comparisons++; if ((d & (m)) !== (e)) begin \
  n_errors++; $display("[FAIL] read %h exp %h got %h", a, e, d & (m)); end end
module switch_bridge_status_regs_tb
  import status_regs_pkg::*;
;
  logic mclk_in = 0, reset_in = 1, restart_in = 0, charge_pump_enable_in = 0, read_valid_out;
  read_req_type read_req_in;
  fault_events_type fault_events_in = '0;
  logic [5:0] bridge_mode_field_in = '0, pwm_pin_in = '0;
  logic [2:0] bridge_output_node_high_in = '0;
  logic [15:0] read_data_out, d;
  int n_errors = 0, comparisons = 0, cycles = 0;
  switch_bridge_status_regs u_dut (.mclk_in, .reset_in, .restart_in, .read_req_in,
    .fault_events_in, .bridge_mode_field_in, .charge_pump_enable_in,
    .bridge_output_node_high_in, .pwm_pin_in, .read_data_out, .read_valid_out);
  status_host_model u_host (.mclk_in, .req_out(read_req_in), .data_in(read_data_out),
    .valid_in(read_valid_out));
  initial forever #2.5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) if (++cycles == 2000) end_of_test();
  task automatic end_of_test();
    if (cycles >= 2000) n_errors++;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic t_flags();
    reset_in <= 0;
    `CHK(FAULT_STATUS_ADDR, 16'h0000, 16'hFFFF)
    for (int i = 0; i < 9; i++) begin
      fault_events_in <= 9'(1 << i);
      @(posedge mclk_in) fault_events_in <= '0;
      `CHK(FAULT_STATUS_ADDR, 16'(1 << (i + 2 * (i / 3))), 16'hFFFF)
      `CHK(FAULT_STATUS_ADDR, 16'h0000, 16'hFFFF)
    end
    fault_events_in <= '1;
    @(posedge mclk_in);
    repeat (2) `CHK(FAULT_STATUS_ADDR, 16'h1CE7, 16'hFFFF)
  endtask
  task automatic t_levels();
    charge_pump_enable_in <= 1;
    bridge_mode_field_in <= 6'h33;
    bridge_output_node_high_in <= 3'h7;
    pwm_pin_in <= 6'h2A;
    repeat (4) @(posedge mclk_in);
    `CHK(GENERAL_STATUS_ADDR, 16'h016A, 16'hFFFF)
    `CHK(7'h47, 16'h0000, 16'hFFFF)
    charge_pump_enable_in <= 0;
    repeat (3) @(posedge mclk_in);
    `CHK(GENERAL_STATUS_ADDR, 16'h002A, 16'hFFFF)
  endtask
  task automatic t_restart();
    restart_in <= 1;
    fault_events_in <= '0;
    @(posedge mclk_in);
    `CHK(FAULT_STATUS_ADDR, 16'h1CE7, 16'hFFFF)
    `CHK(GENERAL_STATUS_ADDR, 16'h0000, 16'hFF3E)
    restart_in <= 0;
  endtask
  initial begin
    repeat (20) @(posedge mclk_in);
    t_flags();
    t_levels();
    t_restart();
    end_of_test();
  end
endmodule
`default_nettype wire
